/* File: design/rpw_pkg.sv */
// Package with offsets, field masks, reset values and states of the alarm and power window block.
package rpw_pkg;
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam logic [7:0] OFF_CONTROL = 8'h00;
    localparam logic [7:0] OFF_CONFIG_CAL = 8'h04;
    localparam logic [7:0] OFF_POINTER = 8'h08;
    localparam logic [7:0] OFF_WIN_HIGH = 8'h0c;
    localparam logic [7:0] OFF_WIN_LOW = 8'h10;
    localparam logic [7:0] OFF_MIN_SEC = 8'h14;
    localparam logic [7:0] OFF_WEEKDAY_DIGIT_HOUR = 8'h18;
    localparam logic [7:0] OFF_MONTH_DAY = 8'h1c;
    localparam logic [7:0] OFF_WIN_TIMER = 8'h20;
    localparam logic [7:0] OFF_STATUS = 8'h24;
    localparam int unsigned CTL_UNLOCK_BIT = 0;
    localparam int unsigned CTL_PWC_ON_BIT = 1;
    localparam int unsigned CTL_PRESCALE_BIT = 2;
    localparam logic [2:0] CONTROL_RESET = 3'h0;
    localparam logic [7:0] CAL_RESET = 8'h00;
    localparam logic [1:0] POINTER_RESET = 2'h0;
    localparam logic [15:0] ALARM_RESET = 16'h0000;
    // Index of each alarm value pair equals the pointer code that selects it.
    localparam int unsigned IDX_MIN_SEC = 0;
    localparam int unsigned IDX_WEEKDAY_DIGIT_HOUR = 1;
    localparam int unsigned IDX_MONTH_DAY = 2;
    localparam int unsigned IDX_WIN_TIMER = 3;
    localparam logic [15:0] MASK_MIN_SEC = 16'h7f7f;
    localparam logic [15:0] MASK_WEEKDAY_DIGIT_HOUR = 16'h073f;
    localparam logic [15:0] MASK_MONTH_DAY = 16'h1f3f;
    localparam logic [15:0] MASK_WIN_TIMER = 16'hffff;
    localparam logic [7:0] WINDOW_NONE = 8'h00;
    localparam logic [7:0] SAMPLE_ALWAYS = 8'hff;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [2:0] {
        PW_IDLE = 3'b001,
        PW_STAB = 3'b010,
        PW_SAMP = 3'b100
    } rpw_state_t;
endpackage

/* File: design/rpw_period_counter.sv */
// Down counter that measures a window of N window-clock periods.
module rpw_period_counter
    import rpw_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic load,
    input wire logic [7:0] load_value,
    input wire logic tick,
    output logic busy,
    output logic expired
);
    logic [7:0] cnt_r;
    logic busy_r;
    logic expired_r;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_r <= 8'h00;
            busy_r <= 1'b0;
            expired_r <= 1'b0;
        end
        else if (load)
        begin
            cnt_r <= load_value;
            busy_r <= (load_value != 8'h00);
            expired_r <= 1'b0;
        end
        else
        begin
            expired_r <= busy_r && tick && (cnt_r == 8'h01);
            if (busy_r && tick)
            begin
                cnt_r <= cnt_r - 8'h01;
                busy_r <= (cnt_r != 8'h01);
            end
        end
    end

    assign busy = busy_r;
    assign expired = expired_r;
endmodule

/* File: design/rpw_top.sv */
// Alarm compare values, power control window timer and calibration adder with AXI4-Lite access.
// Operation
// (R1) Month: one-bit tens at 12, ones 11:8.
// (R2) Day: two-bit tens 5:4, ones 3:0.
// (R3) Weekday: three bits 10:8, values 0-6.
// (R4) Hour: two-bit tens 5:4, ones low nibble.
// (R5) Minute: three-bit tens 14:12, ones 11:8.
// (R6) Second: three-bit tens 6:4, ones 3:0.
// (R7) Unused alarm bits read zero, ignore writes.
// (R8) Locked registers written only while unlocked.
// (R9) Stability window lasts N window periods.
// (R10) Zero stability skips straight to sampling.
// (R11) Sample window lasts N periods, 1-254.
// (R12) All-ones sample field: window always active.
// (R13) Sampling starts when stability window expires.
// (R14) Each minute apply calibration times four.
// (R15) Software signs calibration by oscillator error.
// (R16) Software writes calibration at safe moments.
// (R17) Zero sample field gives no sample window.
// (R18) Pointer picks pair, decrements to zero.
// (R19) Prescale halves the window clock when set.
// (R20) Software enables and routes power control; an all-ones sample field drives the output even while pwc_on is clear.
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
module rpw_top
    import rpw_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic rtc_clk_tick,
    input wire logic alarm_event,
    input wire logic minute_tick,
    output logic power_control_out,
    output logic sample_window_active,
    output logic cal_adjust_valid,
    output logic [9:0] cal_adjust_amount
);
    localparam logic [15:0] FIELD_MASK [4] = '{MASK_MIN_SEC, MASK_WEEKDAY_DIGIT_HOUR, MASK_MONTH_DAY,
        MASK_WIN_TIMER};
    localparam logic [7:0] DIRECT_OFF [4] = '{OFF_MIN_SEC, OFF_WEEKDAY_DIGIT_HOUR, OFF_MONTH_DAY,
        OFF_WIN_TIMER};

    logic [7:0] aw_addr_r;
    logic aw_got_r;
    logic [15:0] w_data_r;
    logic [1:0] w_strb_r;
    logic w_got_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic [2:0] control_r;
    logic [7:0] cal_r;
    logic [1:0] pointer_r;
    logic [1:0] pointer_nxt;
    logic [15:0] alarm_r [4];
    logic [15:0] alarm_nxt [4];
    rpw_state_t state_r;
    rpw_state_t state_nxt;
    logic prescale_phase_r;
    logic power_r;
    logic sample_r;
    logic cal_valid_r;
    logic [9:0] cal_amount_r;

    // Write channel: address and data are taken in either order, one write at a time.
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire do_write = aw_got_r && w_got_r && !bvalid_r;
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire unlocked = control_r[CTL_UNLOCK_BIT];
    wire pwc_on = control_r[CTL_PWC_ON_BIT];

    wire wr_control = do_write && (aw_addr_r == OFF_CONTROL);
    wire wr_cal = do_write && (aw_addr_r == OFF_CONFIG_CAL);
    wire wr_pointer = do_write && (aw_addr_r == OFF_POINTER);
    wire wr_win_high = do_write && (aw_addr_r == OFF_WIN_HIGH);
    wire wr_win_low = do_write && (aw_addr_r == OFF_WIN_LOW);
    wire rd_win_high = ar_take && (s_axi_araddr == OFF_WIN_HIGH);
    wire wr_direct_hit = do_write && (aw_addr_r == OFF_MIN_SEC || aw_addr_r == OFF_WEEKDAY_DIGIT_HOUR
        || aw_addr_r == OFF_MONTH_DAY || aw_addr_r == OFF_WIN_TIMER);
    wire wr_mapped = wr_control || wr_cal || wr_pointer || wr_win_high || wr_win_low
        || wr_direct_hit || (do_write && aw_addr_r == OFF_STATUS);

    wire [7:0] stab_count = alarm_r[IDX_WIN_TIMER][15:8];
    wire [7:0] samp_count = alarm_r[IDX_WIN_TIMER][7:0];
    wire samp_always = (samp_count == SAMPLE_ALWAYS); // R12
    wire samp_timed = (samp_count != WINDOW_NONE) && !samp_always; // R11 R17

    // A divided window clock gives up every other source tick.
    wire window_tick = rtc_clk_tick && (!control_r[CTL_PRESCALE_BIT] || prescale_phase_r); // R19

    wire ctr_busy;
    wire ctr_expired;
    wire start_stab = (state_r == PW_IDLE) && alarm_event && pwc_on
        && (stab_count != WINDOW_NONE); // R9
    wire start_samp_direct = (state_r == PW_IDLE) && alarm_event && pwc_on
        && (stab_count == WINDOW_NONE) && samp_timed; // R10
    wire start_samp_after = (state_r == PW_STAB) && ctr_expired && samp_timed && pwc_on; // R13
    wire ctr_load = start_stab || start_samp_direct || start_samp_after;
    wire [7:0] ctr_value = start_stab ? stab_count : samp_count;

    rpw_period_counter u_window_counter (
        .aclk(aclk),
        .aresetn(aresetn),
        .load(ctr_load),
        .load_value(ctr_value),
        .tick(window_tick),
        .busy(ctr_busy),
        .expired(ctr_expired)
    );

    // Read data mux; the windows return a byte of the pair the pointer selects.
    logic [31:0] rd_mux;
    logic rd_hit;
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        unique case (s_axi_araddr)
            OFF_CONTROL: rd_mux = {29'h0, control_r};
            OFF_CONFIG_CAL: rd_mux = {24'h0, cal_r};
            OFF_POINTER: rd_mux = {30'h0, pointer_r};
            OFF_WIN_HIGH: rd_mux = {24'h0, alarm_r[pointer_r][15:8]};
            OFF_WIN_LOW: rd_mux = {24'h0, alarm_r[pointer_r][7:0]};
            OFF_MIN_SEC: rd_mux = {16'h0, alarm_r[IDX_MIN_SEC]};
            OFF_WEEKDAY_DIGIT_HOUR: rd_mux = {16'h0, alarm_r[IDX_WEEKDAY_DIGIT_HOUR]};
            OFF_MONTH_DAY: rd_mux = {16'h0, alarm_r[IDX_MONTH_DAY]};
            OFF_WIN_TIMER: rd_mux = {16'h0, alarm_r[IDX_WIN_TIMER]};
            OFF_STATUS: rd_mux = {16'h0, 1'b0, ctr_busy, power_r, sample_r, 2'b00,
                cal_amount_r};
            default: rd_hit = 1'b0;
        endcase
    end

    // Alarm value and window timer updates; the masks keep unused bits at zero.
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            alarm_nxt[i] = alarm_r[i];
            if (i == IDX_MIN_SEC || unlocked) // R8
            begin
                if (do_write && aw_addr_r == DIRECT_OFF[i])
                begin
                    if (w_strb_r[1])
                        alarm_nxt[i][15:8] = w_data_r[15:8];
                    if (w_strb_r[0])
                        alarm_nxt[i][7:0] = w_data_r[7:0];
                end
                if (wr_win_high && w_strb_r[0] && pointer_r == 2'(i))
                    alarm_nxt[i][15:8] = w_data_r[7:0];
                if (wr_win_low && w_strb_r[0] && pointer_r == 2'(i))
                    alarm_nxt[i][7:0] = w_data_r[7:0];
            end
            alarm_nxt[i] = alarm_nxt[i] & FIELD_MASK[i]; // R1 R2 R3 R4 R5 R6 R7
        end
    end

    // A high-window access walks the pointer down and parks it at zero.
    always_comb
    begin
        pointer_nxt = pointer_r;
        if (wr_pointer && w_strb_r[0])
            pointer_nxt = w_data_r[1:0];
        else if ((wr_win_high || rd_win_high) && pointer_r != 2'b00)
            pointer_nxt = pointer_r - 2'b01; // R18
    end

    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            PW_IDLE:
            begin
                if (start_stab)
                    state_nxt = PW_STAB;
                else if (start_samp_direct)
                    state_nxt = PW_SAMP;
            end
            PW_STAB:
            begin
                if (!pwc_on)
                    state_nxt = PW_IDLE;
                else if (ctr_expired)
                    state_nxt = samp_timed ? PW_SAMP : PW_IDLE; // R17
            end
            PW_SAMP:
            begin
                if (!pwc_on || ctr_expired)
                    state_nxt = PW_IDLE; // R11
            end
            default: state_nxt = PW_IDLE;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_got_r <= 1'b0;
            w_data_r <= 16'h0000;
            w_strb_r <= 2'b00;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end
        else
        begin
            if (aw_take)
            begin
                aw_got_r <= 1'b1;
                aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (w_take)
            begin
                w_got_r <= 1'b1;
                w_data_r <= s_axi_wdata[15:0];
                w_strb_r <= s_axi_wstrb[1:0];
            end
            if (do_write)
            begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end
            else if (bvalid_r && s_axi_bready)
                bvalid_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= RESP_OKAY;
        end
        else if (ar_take)
        begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_mux;
            rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rvalid_r && s_axi_rready)
            rvalid_r <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            control_r <= CONTROL_RESET;
            cal_r <= CAL_RESET;
            pointer_r <= POINTER_RESET;
            for (int i = 0; i < 4; i++)
                alarm_r[i] <= ALARM_RESET;
        end
        else
        begin
            if (wr_control && w_strb_r[0])
                control_r <= w_data_r[2:0];
            if (wr_cal && w_strb_r[0])
                cal_r <= w_data_r[7:0]; // R16
            pointer_r <= pointer_nxt;
            alarm_r <= alarm_nxt;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_r <= PW_IDLE;
            prescale_phase_r <= 1'b0;
            power_r <= 1'b0;
            sample_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            if (rtc_clk_tick)
                prescale_phase_r <= !prescale_phase_r;
            power_r <= (state_nxt != PW_IDLE) || samp_always;
            sample_r <= (state_nxt == PW_SAMP) || samp_always; // R12 R13
        end
    end

    // The correction is signed so a fast oscillator loses pulses each minute.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cal_valid_r <= 1'b0;
            cal_amount_r <= 10'h000;
        end
        else
        begin
            cal_valid_r <= minute_tick;
            if (minute_tick)
                cal_amount_r <= {cal_r, 2'b00}; // R14 R15
        end
    end

    assign s_axi_awready = !aw_got_r && !bvalid_r;
    assign s_axi_wready = !w_got_r && !bvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign power_control_out = power_r; // R20
    assign sample_window_active = sample_r;
    assign cal_adjust_valid = cal_valid_r;
    assign cal_adjust_amount = cal_amount_r;
endmodule

/* File: testbench/rpw_top_sva.sv */
// Concurrent checks on the ports of the alarm and power window block.
module rpw_top_chk
    import rpw_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic minute_tick,
    input wire logic cal_adjust_valid,
    input wire logic [9:0] cal_adjust_amount,
    input wire logic power_control_out,
    input wire logic sample_window_active,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    cal_pulse_a: assert property (minute_tick |=> cal_adjust_valid)
        else $error("calibration pulse missing");
    cal_once_a: assert property (!minute_tick |=> !cal_adjust_valid)
        else $error("calibration pulse without minute tick");
    cal_hold_a: assert property (!minute_tick |=> $stable(cal_adjust_amount))
        else $error("calibration amount moved between minutes");
    cal_scale_a: assert property (cal_adjust_amount[1:0] == 2'b00)
        else $error("calibration amount not a multiple of four");
    sample_power_a: assert property (sample_window_active |-> power_control_out)
        else $error("sample window without power");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    read_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("unused read bits not zero");
    read_stand_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    write_stand_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
endmodule

bind rpw_top rpw_top_chk chk_u (.aclk(aclk), .aresetn(aresetn), .minute_tick(minute_tick),
    .cal_adjust_valid(cal_adjust_valid), .cal_adjust_amount(cal_adjust_amount),
    .power_control_out(power_control_out), .sample_window_active(sample_window_active),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp));

/* File: testbench/rpw_ext_load.sv */
// Model of the external device that the power control output switches on.
module rpw_ext_load (
    input wire logic aclk,
    input wire logic clear,
    input wire logic power_in,
    input wire logic sample_in,
    input wire logic tick,
    output logic [31:0] power_ticks,
    output logic [31:0] sample_ticks
);
    timeunit 1ns;
    timeprecision 1ps;
    // Counting source clock ticks, not cycles, keeps the result free of output latency.
    always_ff @(posedge aclk)
    begin
        if (clear)
        begin
            power_ticks <= 32'h0;
            sample_ticks <= 32'h0;
        end
        else
        begin
            power_ticks <= power_ticks + 32'(power_in && tick);
            sample_ticks <= sample_ticks + 32'(sample_in && tick);
        end
    end
endmodule

/* File: testbench/tb.sv */
// Self-checking testbench for the alarm and power window block.
module tb
    import rpw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic tick = 1'b0, alarm = 1'b0, minute = 1'b0, clr = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, c;
    logic [31:0] wdata = 32'h0, rdata, pw_ticks, sm_ticks, d, cyc = 32'h0;
    logic awready, wready, bvalid, arready, rvalid, pwr, smp, cal_v;
    logic [1:0] bresp, rresp, last_resp;
    logic [9:0] cal_amt;
    logic [15:0] expv[4];
    logic [7:0] addr[4] = '{OFF_MIN_SEC, OFF_WEEKDAY_DIGIT_HOUR, OFF_MONTH_DAY, OFF_WIN_TIMER};
    logic [15:0] mask[4] = '{MASK_MIN_SEC, MASK_WEEKDAY_DIGIT_HOUR, MASK_MONTH_DAY, MASK_WIN_TIMER};
    logic [7:0] cal_tab[4] = '{8'h00, 8'h7f, 8'h80, 8'hff};
    int errors = 0, n_checks = 0, i;

    rpw_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'h3), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .rtc_clk_tick(tick),
        .alarm_event(alarm), .minute_tick(minute), .power_control_out(pwr),
        .sample_window_active(smp), .cal_adjust_valid(cal_v), .cal_adjust_amount(cal_amt));
    rpw_ext_load load_u (.aclk(aclk), .clear(clr), .power_in(pwr), .sample_in(smp),
        .tick(tick), .power_ticks(pw_ticks), .sample_ticks(sm_ticks));

    initial
    begin
        forever #2 aclk = ~aclk;
    end
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        tick <= (cyc[2:0] == 3'h7);
    end

    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic hang();
        errors++;
        tally_and_finish();
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int n;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
            if (bvalid)
                break;
        end
        last_resp = bresp;
        if (n == 50)
            hang();
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'b0;
            if (rvalid)
                break;
        end
        v = rdata;
        last_resp = rresp;
        if (n == 50)
            hang();
    endtask
    function automatic logic [9:0] cal_exp(input logic [7:0] v);
        return {v, 2'b00};
    endfunction
    // Alarm is placed two cycles after a tick so the window edges never race a tick.
    task automatic win(input logic [7:0] st, input logic [7:0] sa, input logic pre);
        logic [31:0] e;
        logic [31:0] es;
        es = (sa == WINDOW_NONE || sa == SAMPLE_ALWAYS) ? 32'h0 : 32'(sa);
        e = 32'(st) + es;
        wr(OFF_CONTROL, {29'h0, pre, 2'b11});
        wr(OFF_WIN_TIMER, {16'h0, st, sa});
        clr <= 1'b1;
        @(posedge aclk);
        clr <= 1'b0;
        while (cyc[2:0] != 3'h1)
            @(posedge aclk);
        alarm <= 1'b1;
        @(posedge aclk);
        alarm <= 1'b0;
        repeat ((e + 3) * 16) @(posedge aclk);
        if (pre)
            chk(32'(pw_ticks >= 2 * e - 1 && pw_ticks <= 2 * e + 1), 1);
        else
            chk(pw_ticks, e);
        if (!pre)
            chk(sm_ticks, es);
        chk(pwr, 0);
    endtask

    initial
    begin
        void'($urandom(54617));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (i = 0; i < 10; i++)
        begin
            rd(8'(i * 4), d);
            chk(d, 0);
        end
        rd(8'h30, d);
        chk(d, 0);
        chk(32'(last_resp), 32'(RESP_SLVERR));
        wr(8'h30, 32'h1);
        chk(last_resp, RESP_SLVERR);
        wr(OFF_CONTROL, 32'h1);
        for (i = 0; i < 8; i++)
        begin
            d = (i < 4) ? 32'hffffffff : $urandom;
            wr(addr[i % 4], d);
            expv[i % 4] = d[15:0] & mask[i % 4];
            rd(addr[i % 4], d);
            chk(d, expv[i % 4]);
        end
        wr(OFF_CONTROL, 32'h0);
        for (i = 0; i < 4; i++)
        begin
            wr(addr[i], ~expv[i]);
            if (i == 0)
                expv[0] = ~expv[0] & mask[0];
            rd(addr[i], d);
            chk(d, expv[i]);
        end
        wr(OFF_POINTER, 32'h3);
        for (i = 3; i >= -1; i--)
        begin
            rd(OFF_WIN_HIGH, d);
            chk(d, expv[i < 0 ? 0 : i][15:8]);
        end
        rd(OFF_POINTER, d);
        chk(d, 0);
        wr(OFF_POINTER, 32'h2);
        rd(OFF_WIN_LOW, d);
        chk(d, expv[2][7:0]);
        rd(OFF_POINTER, d);
        chk(d, 2);
        // Window writes: the low half leaves the pointer, the high half walks it down.
        wr(OFF_CONTROL, 32'h1);
        wr(OFF_WIN_LOW, 32'h1a);
        wr(OFF_WIN_HIGH, 32'h11);
        expv[2] = 16'h111a & mask[2];
        rd(addr[2], d);
        chk(d, expv[2]);
        rd(OFF_POINTER, d);
        chk(d, 1);
        wr(OFF_CONTROL, 32'h0);
        wr(OFF_WIN_HIGH, 32'h07);
        rd(OFF_POINTER, d);
        chk(d, 0);
        rd(addr[1], d);
        chk(d, expv[1]);
        // Calibration is written while no window runs, the safe moment for software.
        for (i = 0; i < 6; i++)
        begin
            c = (i < 4) ? cal_tab[i] : 8'($urandom);
            wr(OFF_CONFIG_CAL, {24'h0, c});
            minute <= 1'b1;
            @(posedge aclk);
            minute <= 1'b0;
            @(posedge aclk);
            chk(cal_v, 1);
            chk(cal_amt, cal_exp(c));
        end
        win(8'h00, 8'h05, 1'b0);
        win(8'h03, 8'h00, 1'b0);
        win(8'h00, 8'h00, 1'b0);
        win(8'hff, 8'h01, 1'b0);
        win(8'h01, 8'hfe, 1'b0);
        win(8'h03, 8'h04, 1'b1);
        for (i = 0; i < 3; i++)
            win(8'($urandom_range(1, 9)), 8'($urandom_range(1, 20)), 1'b0);
        wr(OFF_CONTROL, 32'h1);
        wr(OFF_WIN_TIMER, 32'h00ff);
        repeat (4) @(posedge aclk);
        chk(smp, 1);
        chk(pwr, 1);
        tally_and_finish();
    end
endmodule
